// ### common/ufc_regs.svh
// Register map, field positions and timing constants of the serial line configuration block.
// Behaviour
// R1: Bit 7 ties transmitter output to receiver.
// R2: Tied mode ignores the receive pin entirely.
// R3: Bit 6 freezes transceiver clocks in wait.
// R4: Receiver source bit matters only when tied.
// R5: Tied with source 0: internal loopback.
// R6: Tied with source 1: single wire on transmit pin.
// R7: Bit 4 clear: start, 8 data lsb-first, stop.
// R8: Bit 4 set: ninth data bit before stop.
// R9: Bit 3 picks idle-line or address-mark wake.
// R10: Idle needs 10/11 high bit times; bit 2 origin.
// R11: Origin after stop excludes stop and trailing ones.
// R12: Bit 1 enables parity on character msb.
// R13: Bit 0 picks even or odd parity.
// R14: Bit time is clock over 16 times divisor.
// R15: Stop count select gives one or two stops.
// R16: Failed parity sets readable error flag.
// R17: Configuration resets to zero, normal mode.
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// ----------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------
`define UFC_IDX_DIVISOR   3'h0
`define UFC_IDX_CTRL      3'h1
`define UFC_IDX_LINE_CFG  3'h2
`define UFC_IDX_STATUS    3'h3
`define UFC_IDX_IRQ_EN    3'h4
`define UFC_IDX_IRQ_CLR   3'h5
`define UFC_IDX_DATA      3'h6
// ----------------------------------------------------------------
// Line configuration fields.
// ----------------------------------------------------------------
`define UFC_CFG_TIE       7
`define UFC_CFG_FREEZE    6
`define UFC_CFG_RX_SOURCE_SELECT      5
`define UFC_CFG_NINE      4
`define UFC_CFG_WAKE      3
`define UFC_CFG_IDLE_ORG  2
`define UFC_CFG_PAR_ON    1
`define UFC_CFG_PAR_ODD   0
`define UFC_CFG_RESET     8'h00
// ----------------------------------------------------------------
// Control fields and status event bits.
// ----------------------------------------------------------------
`define UFC_CTL_TX_EN     0
`define UFC_CTL_RX_EN     1
`define UFC_CTL_TWO_STOP  2
`define UFC_CTL_TX_DIR    3
`define UFC_CTL_SLEEP     4
`define UFC_CTL_NINTH     5
`define UFC_CTL_RESET     6'h00
`define UFC_EV_RX_DONE    0
`define UFC_EV_TX_DONE    1
`define UFC_EV_IDLE       2
`define UFC_EV_PAR_ERR    3
`define UFC_EV_RESET      4'h0
// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define UFC_OVERSAMPLE    5'h10
`define UFC_IDLE_BITS_8   8'h0a
`define UFC_IDLE_BITS_9   8'h0b
`endif

// ### common/ufc_pkg.sv
// Types shared by the serial line configuration block.
package ufc_pkg;
    typedef enum logic [0:0] {
        UFC_TX_IDLE  = 1'b0,
        UFC_TX_SHIFT = 1'b1
    } ufc_tx_state_e;
    typedef enum logic [1:0] {
        UFC_RX_IDLE  = 2'b00,
        UFC_RX_START = 2'b01,
        UFC_RX_DATA  = 2'b10,
        UFC_RX_STOP  = 2'b11
    } ufc_rx_state_e;
    typedef logic [12:0] ufc_divisor_t;
endpackage

// ### logic/ufc_baud_gen.sv
// Oversampling tick generator: one tick every divisor clocks.
`timescale 1ns/100ps
`default_nettype none
module ufc_baud_gen #(
    parameter int DIV_W = 13
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [DIV_W-1:0] divisor_in,
    input  wire logic             freeze_in,
    output logic                  tick_out
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             wrap;
    logic             tick_next;

    // A zero divisor parks the counter and no tick is made. [R14]
    assign wrap      = (cnt_reg >= divisor_in - {{(DIV_W-1){1'b0}}, 1'b1});
    assign tick_next = (divisor_in != '0) && !freeze_in && wrap;
    assign cnt_next  = (divisor_in == '0) ? '0 :
                       freeze_in ? cnt_reg :
                       wrap ? '0 : cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg  <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_out <= tick_next;
        end
    end
endmodule
`default_nettype wire

// ### logic/ufc_top.sv
// Serial transceiver with line configuration register, loop modes and parity.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ufc_regs.svh"
module ufc_top (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [4:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        cpu_wait_in,
    input  wire logic        rxd_in,
    input  wire logic        txd_in,
    output logic             txd_out,
    output logic             txd_oe_n_out,
    output logic             clk_frozen_out,
    output logic             irq_out
);
    // ----------------------------------------------------------------
    // Register bus slave.
    // ----------------------------------------------------------------
    logic [7:0]        cfg_reg;
    logic [5:0]        ctl_reg;
    ufc_pkg::ufc_divisor_t div_reg;
    logic [3:0]        stat_reg;
    logic [3:0]        ien_reg;
    logic [8:0]        rx_data_reg;
    logic [2:0]        idx;
    logic              req;
    logic              wr_take;
    logic              rd_hit;
    logic [31:0]       rd_mux;
    logic              lane0;
    logic              lane1;

    assign idx     = wb_adr_in[4:2];
    assign req     = wb_cyc_in && wb_stb_in;
    assign wr_take = req && wb_we_in && wb_ack_out;
    assign lane0   = wb_sel_in[0];
    assign lane1   = wb_sel_in[1];
    assign rd_hit  = req && !wb_ack_out;
    assign rd_mux  = (idx == `UFC_IDX_DIVISOR)  ? {19'h0, div_reg} :
                     (idx == `UFC_IDX_CTRL)     ? {26'h0, ctl_reg} :
                     (idx == `UFC_IDX_LINE_CFG) ? {24'h0, cfg_reg} :
                     (idx == `UFC_IDX_STATUS)   ? {28'h0, stat_reg} :
                     (idx == `UFC_IDX_IRQ_EN)   ? {28'h0, ien_reg} :
                     (idx == `UFC_IDX_DATA)     ? {23'h0, rx_data_reg} : 32'h0;

    // Writes land on the edge where the master samples the acknowledge.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= rd_hit;
            wb_dat_out <= rd_hit ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode.
    // ----------------------------------------------------------------
    logic tie;
    logic rx_source_select;
    logic nine;
    logic par_on;
    logic par_odd;
    logic freeze;
    logic tick;
    logic tx_line_reg;
    logic rx_src;
    logic drive_pin;

    assign tie     = cfg_reg[`UFC_CFG_TIE];
    assign rx_source_select    = cfg_reg[`UFC_CFG_RX_SOURCE_SELECT];
    assign nine    = cfg_reg[`UFC_CFG_NINE];
    assign par_on  = cfg_reg[`UFC_CFG_PAR_ON];
    assign par_odd = cfg_reg[`UFC_CFG_PAR_ODD];
    assign freeze  = cfg_reg[`UFC_CFG_FREEZE] && cpu_wait_in;              // [R3]
    // The receive pin is never looked at while tied; the source bit only acts then.
    assign rx_src  = !tie ? rxd_in : (rx_source_select ? txd_in : tx_line_reg);        // [R1] [R2] [R4] [R5] [R6]
    // In single-wire mode the direction bit hands the pin to the far end.
    assign drive_pin = ctl_reg[`UFC_CTL_TX_EN] && !(tie && rx_source_select && !ctl_reg[`UFC_CTL_TX_DIR]); // [R6]

    ufc_baud_gen #(
        .DIV_W (13)
    ) u_baud (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .divisor_in (div_reg),
        .freeze_in  (freeze),
        .tick_out   (tick)
    );

    // ----------------------------------------------------------------
    // Transmitter.
    // ----------------------------------------------------------------
    ufc_pkg::ufc_tx_state_e tx_state_reg;
    logic [11:0] tx_sh_reg;
    logic [3:0]  tx_bits_reg;
    logic [3:0]  tx_sub_reg;
    logic        tx_load;
    logic        tx_end;
    logic [8:0]  tx_d9;
    logic [11:0] tx_frame;
    logic [3:0]  tx_nbits;

    assign tx_load  = wr_take && lane0 && (idx == `UFC_IDX_DATA) &&
                      ctl_reg[`UFC_CTL_TX_EN] && (tx_state_reg == ufc_pkg::UFC_TX_IDLE);
    // Parity replaces the character msb: bit 8 or bit 7. [R12] [R13]
    assign tx_d9[6:0] = wb_dat_in[6:0];
    assign tx_d9[7]   = (par_on && !nine) ? (^wb_dat_in[6:0] ^ par_odd) : wb_dat_in[7];
    assign tx_d9[8]   = (par_on && nine) ? (^wb_dat_in[7:0] ^ par_odd) : ctl_reg[`UFC_CTL_NINTH];
    assign tx_frame   = nine ? {2'b11, tx_d9, 1'b0} : {3'b111, tx_d9[7:0], 1'b0}; // [R7] [R8]
    // Start + data + one or two stops. [R15]
    assign tx_nbits   = (nine ? 4'ha : 4'h9) + (ctl_reg[`UFC_CTL_TWO_STOP] ? 4'h2 : 4'h1);
    assign tx_end     = (tx_state_reg == ufc_pkg::UFC_TX_SHIFT) && tick &&
                        (tx_sub_reg == 4'hf) && (tx_bits_reg == 4'h1);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_state_reg <= ufc_pkg::UFC_TX_IDLE;
            tx_sh_reg    <= 12'hfff;
            tx_bits_reg  <= 4'h0;
            tx_sub_reg   <= 4'h0;
        end else begin
            case (tx_state_reg)
                ufc_pkg::UFC_TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_reg <= ufc_pkg::UFC_TX_SHIFT;
                        tx_sh_reg    <= tx_frame;
                        tx_bits_reg  <= tx_nbits;
                        tx_sub_reg   <= 4'h0;
                    end
                end
                ufc_pkg::UFC_TX_SHIFT: begin
                    if (tick) begin
                        // Sixteen ticks per bit time. [R14]
                        tx_sub_reg <= tx_sub_reg + 4'h1;
                        if (tx_sub_reg == 4'hf) begin
                            tx_sh_reg   <= {1'b1, tx_sh_reg[11:1]};
                            tx_bits_reg <= tx_bits_reg - 4'h1;
                            if (tx_bits_reg == 4'h1) begin
                                tx_state_reg <= ufc_pkg::UFC_TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    tx_state_reg <= ufc_pkg::UFC_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_line_reg  <= 1'b1;
            txd_out      <= 1'b1;
            txd_oe_n_out <= 1'b1;
        end else begin
            tx_line_reg  <= (tx_state_reg == ufc_pkg::UFC_TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
            txd_out      <= (tx_state_reg == ufc_pkg::UFC_TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
            txd_oe_n_out <= !drive_pin;
        end
    end

    // ----------------------------------------------------------------
    // Receiver, wake-up and idle detection.
    // ----------------------------------------------------------------
    ufc_pkg::ufc_rx_state_e rx_state_reg;
    logic [8:0] rx_sh_reg;
    logic [3:0] rx_sub_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] idle_cnt_reg;
    logic       idle_armed_reg;
    logic       rx_mid;
    logic       rx_last;
    logic       rx_end;
    logic [8:0] rx_char;
    logic       rx_msb;
    logic       par_bad;
    logic       mark_wake;
    logic       idle_ev;
    logic       idle_count;
    logic [7:0] idle_need;
    logic       asleep;
    logic       rx_done_ev;

    assign rx_mid    = tick && (rx_sub_reg == 4'hf);
    assign rx_last   = rx_bit_reg == (nine ? 4'h8 : 4'h7);
    assign rx_end    = (rx_state_reg == ufc_pkg::UFC_RX_STOP) && rx_mid;
    assign rx_char   = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};               // [R7] [R8]
    assign rx_msb    = nine ? rx_sh_reg[8] : rx_sh_reg[8];
    // Ones over the whole character, parity bit included. [R13]
    assign par_bad   = par_on && ((^rx_char) != par_odd);
    assign asleep    = ctl_reg[`UFC_CTL_SLEEP];
    assign mark_wake = rx_end && cfg_reg[`UFC_CFG_WAKE] && rx_msb;             // [R9]
    assign rx_done_ev = rx_end && (!asleep || mark_wake);
    // After the stop bit, only the idle state counts toward the line idle. [R10] [R11]
    assign idle_count = rx_src && (cfg_reg[`UFC_CFG_IDLE_ORG] ?
                        (rx_state_reg == ufc_pkg::UFC_RX_IDLE) :
                        (rx_state_reg != ufc_pkg::UFC_RX_START));
    assign idle_need  = (nine ? `UFC_IDLE_BITS_9 : `UFC_IDLE_BITS_8) << 4;      // [R10]
    assign idle_ev    = idle_armed_reg && (idle_cnt_reg == idle_need);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_state_reg <= ufc_pkg::UFC_RX_IDLE;
            rx_sh_reg    <= 9'h0;
            rx_sub_reg   <= 4'h0;
            rx_bit_reg   <= 4'h0;
        end else begin
            if (tick) begin
                rx_sub_reg <= rx_sub_reg + 4'h1;
            end
            case (rx_state_reg)
                ufc_pkg::UFC_RX_IDLE: begin
                    if (tick && !rx_src && ctl_reg[`UFC_CTL_RX_EN]) begin
                        rx_state_reg <= ufc_pkg::UFC_RX_START;
                        rx_sub_reg   <= 4'h8;
                    end
                end
                ufc_pkg::UFC_RX_START: begin
                    if (rx_mid) begin
                        rx_state_reg <= rx_src ? ufc_pkg::UFC_RX_IDLE : ufc_pkg::UFC_RX_DATA;
                        rx_bit_reg   <= 4'h0;
                    end
                end
                ufc_pkg::UFC_RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_reg  <= {rx_src, rx_sh_reg[8:1]};
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_last) begin
                            rx_state_reg <= ufc_pkg::UFC_RX_STOP;
                        end
                    end
                end
                ufc_pkg::UFC_RX_STOP: begin
                    if (rx_mid) begin
                        rx_state_reg <= ufc_pkg::UFC_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= ufc_pkg::UFC_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            idle_cnt_reg   <= 8'h0;
            idle_armed_reg <= 1'b0;
            rx_data_reg    <= 9'h0;
        end else begin
            if (!idle_count) begin
                idle_cnt_reg <= 8'h0;
            end else if (tick && idle_cnt_reg != idle_need) begin
                idle_cnt_reg <= idle_cnt_reg + 8'h1;
            end
            idle_armed_reg <= rx_end || (idle_armed_reg && !idle_ev);
            if (rx_done_ev) begin
                rx_data_reg <= rx_char;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration, control, status and interrupt.
    // ----------------------------------------------------------------
    logic [3:0] ev;
    logic [3:0] clr;
    logic       wake_now;

    assign ev       = {rx_done_ev && par_bad, idle_ev, tx_end, rx_done_ev};    // [R16]
    assign clr      = (wr_take && lane0 && idx == `UFC_IDX_IRQ_CLR) ? wb_dat_in[3:0] : 4'h0;
    assign wake_now = mark_wake || (idle_ev && !cfg_reg[`UFC_CFG_WAKE]);        // [R9]

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_reg        <= `UFC_CFG_RESET;                                   // [R17]
            ctl_reg        <= `UFC_CTL_RESET;
            div_reg        <= 13'h0000;
            ien_reg        <= `UFC_EV_RESET;
            stat_reg       <= `UFC_EV_RESET;
            irq_out        <= 1'b0;
            clk_frozen_out <= 1'b0;
        end else begin
            if (wr_take && lane0 && idx == `UFC_IDX_LINE_CFG) begin
                cfg_reg <= wb_dat_in[7:0];
            end
            if (wr_take && lane0 && idx == `UFC_IDX_CTRL) begin
                ctl_reg <= wb_dat_in[5:0];
            end else if (wake_now) begin
                ctl_reg[`UFC_CTL_SLEEP] <= 1'b0;
            end
            if (wr_take && idx == `UFC_IDX_DIVISOR) begin
                div_reg[7:0]  <= lane0 ? wb_dat_in[7:0] : div_reg[7:0];
                div_reg[12:8] <= lane1 ? wb_dat_in[12:8] : div_reg[12:8];
            end
            if (wr_take && lane0 && idx == `UFC_IDX_IRQ_EN) begin
                ien_reg <= wb_dat_in[3:0];
            end
            // A new event beats a clear in the same cycle.
            stat_reg       <= (stat_reg & ~clr) | ev;
            irq_out        <= |(stat_reg & ien_reg);
            clk_frozen_out <= freeze;
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    loop_internal_a: assert property (tie && !rx_source_select |-> rx_src == txd_out) // [R5]
        else $error("internal loop does not feed the transmitter output");
    pin_ignored_a: assert property (tie && $stable(cfg_reg) && $stable(txd_in) && $stable(tx_line_reg) // [R2]
        |-> $stable(rx_src))
        else $error("receive pin reached the receiver while tied");
    src_noeffect_a: assert property (!tie && !$past(tie) && $stable(rxd_in) |-> $stable(rx_src)) // [R4]
        else $error("source select acted outside tied mode");
    single_wire_a: assert property (tie && rx_source_select && !ctl_reg[`UFC_CTL_TX_DIR] && $stable(cfg_reg) // [R6]
        && $stable(ctl_reg) |-> txd_oe_n_out && rx_src == txd_in)
        else $error("single-wire receiver not on transmit pin");
    wait_freeze_a: assert property (freeze |=> !tick) // [R3]
        else $error("tick ran while frozen");
    divisor_zero_a: assert property (div_reg == 13'h0 |=> !tick) // [R14]
        else $error("tick with zero divisor");
    tick_spacing_a: assert property (tick && div_reg > 13'h1 && !freeze |=> !tick) // [R14]
        else $error("ticks closer than the divisor");
    start_bit_a: assert property (tx_load |-> ##2 !txd_out) // [R7]
        else $error("frame does not open with a start bit");
    tx_parity_a: assert property (tx_load && par_on |=> (nine ? ^tx_sh_reg[9:1] : ^tx_sh_reg[8:1]) == par_odd) // [R13]
        else $error("generated parity wrong");
    stop_count_a: assert property (tx_load |=> tx_bits_reg == tx_nbits) // [R15]
        else $error("frame length wrong");
    par_flag_a: assert property (rx_done_ev && par_bad |=> stat_reg[`UFC_EV_PAR_ERR]) // [R16]
        else $error("parity error not flagged");
    idle_len_a: assert property (idle_ev |-> idle_cnt_reg == (nine ? 8'hb0 : 8'ha0)) // [R10]
        else $error("idle flagged at wrong count");
    irq_level_a: assert property (|(stat_reg & ien_reg) |=> irq_out)
        else $error("interrupt not raised");

    loop_rx_c: cover property (tie && !rx_source_select && rx_done_ev);
    wire_rx_c: cover property (tie && rx_source_select && rx_done_ev);
    par_err_c: cover property (rx_done_ev && par_bad);
    idle_c:    cover property (idle_ev);
endmodule
`default_nettype wire

// ### test/ufc_remote_node.sv
// Remote serial node that sends frames on the shared line.
`timescale 1ns/100ps
`default_nettype none
module ufc_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [8:0] data_in,
    input  wire logic       nine_in,
    output logic            line_out,
    output logic            busy_out
);
    logic [11:0] shift_reg;
    int          cnt_reg = 0;
    int          left_reg = 0;
    assign busy_out = (left_reg != 0);
    // The line idles high between frames, as a pulled-up wire does.
    assign line_out = busy_out ? shift_reg[0] : 1'b1;
    always @(posedge clk_in) begin
        if (busy_out) begin
            cnt_reg <= (cnt_reg == BIT_CLKS - 1) ? 0 : cnt_reg + 1;
            if (cnt_reg == BIT_CLKS - 1) begin
                shift_reg <= {1'b1, shift_reg[11:1]};
                left_reg <= left_reg - 1;
            end
        end else if (go_in) begin
            // Start bit, data lsb first, ninth bit when asked, then stop bits.
            shift_reg <= nine_in ? {2'b11, data_in, 1'b0} : {3'b111, data_in[7:0], 1'b0};
            cnt_reg <= 0;
            left_reg <= 12;
        end
    end
endmodule
`default_nettype wire

// ### test/uart_frame_control_tb_top.sv
// Self-checking bench for the serial line configuration block.
`timescale 1ns/100ps
`default_nettype none
module uart_frame_control_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic        cpu_wait = 1'b0;
    logic        go = 1'b0;
    logic [8:0]  nd = 9'h000;
    logic        nine = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        line;
    logic        busy;
    logic        txd;
    logic        oe_n;
    logic        frozen;
    logic        irq;
    logic [31:0] q;
    logic [9:0]  fr;
    int          fail_count = 0;
    int          compares = 0;
    int          lo = 0;
    int          ph = 0;
    logic [7:0]  t_cfg [5] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13};
    logic [8:0]  t_dat [5] = '{9'h0a5, 9'h083, 9'h003, 9'h0a5, 9'h0a5};
    int          t_nb [5] = '{9, 9, 9, 10, 10};
    logic [9:0]  t_exp [5] = '{10'h1a5, 10'h103, 10'h183, 10'h2a5, 10'h3a5};
    always #50 clk = ~clk;
    ufc_top ufc_top_i (.clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .cpu_wait_in(cpu_wait), .rxd_in(line), .txd_in(oe_n ? line : txd), .txd_out(txd),
        .txd_oe_n_out(oe_n), .clk_frozen_out(frozen), .irq_out(irq));
    ufc_remote_node ufc_remote_node_i (.clk_in(clk), .go_in(go), .data_in(nd), .nine_in(nine),
        .line_out(line), .busy_out(busy));
    task automatic finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic give_up;
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        finish_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) give_up();
    endtask
    task automatic send(input logic n9, input logic [8:0] d);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        nine <= n9;
        nd <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic get_tx(input int nb);
        int n;
        n = 0;
        fr = '0;
        while (txd !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (txd !== 1'b0) give_up();
        repeat (8) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (16) @(posedge clk);
            fr[i] = txd;
        end
        repeat (16) @(posedge clk);
    endtask
    task automatic wait_rx(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, 5'h0c, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 200);
        if (q[b] !== 1'b1) give_up();
    endtask
    task automatic rx_case(input logic [7:0] cfg, input logic n9, input logic [8:0] d);
        bus(1'b1, 5'h14, 32'hf);
        bus(1'b1, 5'h08, {24'h0, cfg});
        send(n9, d);
        wait_rx(0);
        bus(1'b0, 5'h18, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 5'h08, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 5'h08, 32'hff);
        bus(1'b0, 5'h08, 32'h0);
        chk(q, 32'hff);
        bus(1'b0, 5'h1c, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b1, 5'h04, 32'h3);
        foreach (t_cfg[k]) begin
            bus(1'b1, 5'h08, {24'h0, t_cfg[k]});
            bus(1'b1, 5'h18, {23'h0, t_dat[k]});
            get_tx(t_nb[k]);
            chk({22'h0, fr}, {22'h0, t_exp[k]});
        end
        rx_case(8'h20, 1'b0, 9'h069);
        chk(q, 32'h69);
        wait_rx(2);
        chk(q & 32'h4, 32'h4);
        rx_case(8'h10, 1'b1, 9'h1c3);
        chk(q, 32'h1c3);
        rx_case(8'h02, 1'b0, 9'h080);
        bus(1'b0, 5'h0c, 32'h0);
        chk(q & 32'h8, 32'h8);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 5'h10, 32'h8);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 5'h14, 32'h8);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 5'h10, 32'h0);
        bus(1'b1, 5'h14, 32'hf);
        bus(1'b1, 5'h08, 32'h80);
        bus(1'b1, 5'h18, 32'h5a);
        // Traffic on the receive pin must not reach the receiver here.
        send(1'b0, 9'h000);
        wait_rx(0);
        bus(1'b0, 5'h18, 32'h0);
        chk(q, 32'h5a);
        rx_case(8'ha0, 1'b0, 9'h096);
        chk(q, 32'h96);
        chk({31'h0, oe_n}, 32'h1);
        // Asleep with address-mark wake: only a character with its msb set gets through.
        bus(1'b1, 5'h14, 32'hf);
        bus(1'b1, 5'h04, 32'h13);
        bus(1'b1, 5'h08, 32'h08);
        send(1'b0, 9'h041);
        repeat (220) @(posedge clk);
        bus(1'b0, 5'h0c, 32'h0);
        chk(q & 32'h1, 32'h0);
        rx_case(8'h08, 1'b0, 9'h081);
        chk(q, 32'h81);
        bus(1'b0, 5'h04, 32'h0);
        chk(q, 32'h3);
        bus(1'b1, 5'h08, 32'h40);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, frozen}, 32'h1);
        bus(1'b1, 5'h08, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, frozen}, 32'h0);
        // With divisor 3 a whole data bit lasts 48 clocks.
        bus(1'b1, 5'h00, 32'h3);
        bus(1'b1, 5'h18, 32'hfd);
        repeat (200) begin
            @(posedge clk);
            if (txd === 1'b0 && ph == 0) ph = 1;
            else if (txd === 1'b1 && ph == 1) ph = 2;
            else if (txd === 1'b0 && ph == 2) lo++;
        end
        chk(lo, 32'h30);
        finish_test();
    end
endmodule
`default_nettype wire
